// *** rsc_cfg.svh ***
/*
 * Constant layout of the reset source combiner: register offsets,
 * cause flag positions and reset values.
 * Assumes inclusion by bare name from the combiner and its testbench.
 */
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define RSC_OFF_CAUSE 8'h00
`define RSC_OFF_IRQ_STAT 8'h04
`define RSC_OFF_IRQ_MASK 8'h08
`define RSC_OFF_LIVE 8'h0c

// ----------------------------------------------------------------
// Cause flag positions
// ----------------------------------------------------------------
`define RSC_BIT_TRAP 15
`define RSC_BIT_OPCODE 14
`define RSC_BIT_CFG 9
`define RSC_BIT_EXT 7
`define RSC_BIT_INSTR 6
`define RSC_BIT_WDOG 4
`define RSC_BIT_BROWN 1
`define RSC_BIT_POWER 0

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define RSC_CAUSE_POR_VAL 16'h0003
`define RSC_CAUSE_IMPL 16'hc2d3
`define RSC_ZERO_VAL 16'h0000
`define RSC_LIVE_W 9

`endif

// *** rsc_combiner.sv ***
/*
 * Reset source combiner: gathers the reset sources into one master
 * reset, records per-source cause flags and raises an interrupt on
 * reset events.
 * Assumes rst_n_in is the power-on reset, the pin and brown-out
 * inputs are asynchronous and all other sources come from logic on
 * sys_clk_in.
 */
// Summary of operation
// - Any active source asserts master reset
// - Nine reset sources are accepted
// - Each reset sets a cause flag; opcode and wreg share one
// - Power-on clears flags, sets brown-out, power-on
// - Software may set or clear flags
// - Software flag set never causes reset
// - Master reset forces defined state, others kept
`timescale 1ns/1ps
`include "rsc_cfg.svh"

module rsc_combiner
	import rsc_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 16
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic external_pin_reset_in,
	input wire logic reset_instruction_event_in,
	input wire logic watchdog_timeout_reset_in,
	input wire logic brown_out_reset_in,
	input wire logic config_mismatch_reset_in,
	input wire logic trap_conflict_reset_in,
	input wire logic illegal_opcode_reset_in,
	input wire logic uninit_wreg_reset_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	output logic [DATA_W-1:0] rd_data_out,
	output logic master_reset_out,
	output logic irq_out
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	generate
		if (DATA_W != 16) begin : g_bad_data
			$error("rsc_combiner needs DATA_W of 16");
		end
		if (ADDR_W < 4) begin : g_bad_addr
			$error("rsc_combiner needs ADDR_W of 4 or more");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	function automatic rsc_sel_type reg_decode(input logic [ADDR_W-1:0] a);
		logic [7:0] lo;
		lo = 8'(a);
		if (a != ADDR_W'(lo)) begin
			reg_decode = RSC_SEL_NONE;
		end else begin
			case (lo)
				`RSC_OFF_CAUSE: reg_decode = RSC_SEL_CAUSE;
				`RSC_OFF_IRQ_STAT: reg_decode = RSC_SEL_IRQ_STAT;
				`RSC_OFF_IRQ_MASK: reg_decode = RSC_SEL_IRQ_MASK;
				`RSC_OFF_LIVE: reg_decode = RSC_SEL_LIVE;
				default: reg_decode = RSC_SEL_NONE;
			endcase
		end
	endfunction : reg_decode

	rsc_sel_type wr_sel;
	rsc_sel_type rd_sel;
	logic wr_cause;
	logic wr_irq_stat;
	logic wr_irq_mask;

	assign wr_sel = reg_decode(addr_in);
	assign rd_sel = reg_decode(addr_in);
	assign wr_cause = wr_en_in && (wr_sel == RSC_SEL_CAUSE);
	assign wr_irq_stat = wr_en_in && (wr_sel == RSC_SEL_IRQ_STAT);
	assign wr_irq_mask = wr_en_in && (wr_sel == RSC_SEL_IRQ_MASK);

	// ----------------------------------------------------------------
	// Source conditioning
	// ----------------------------------------------------------------
	logic [1:0] pin_level;
	logic ext_src;
	logic brown_src;

	// Pin and analog detector are asynchronous to the core clock
	rsc_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.async_in({brown_out_reset_in, external_pin_reset_in}),
		.level_out(pin_level)
	);

	assign ext_src = pin_level[0];
	assign brown_src = pin_level[1];

	logic [`RSC_LIVE_W-1:0] src_live;
	logic src_any;

	assign src_live = {
		uninit_wreg_reset_in,
		illegal_opcode_reset_in,
		trap_conflict_reset_in,
		config_mismatch_reset_in,
		brown_src,
		watchdog_timeout_reset_in,
		reset_instruction_event_in,
		ext_src,
		~rst_n_in
	};

	// Cause flags never feed back, so software sets cannot reset
	assign src_any = |src_live;

	// ----------------------------------------------------------------
	// Master reset
	// ----------------------------------------------------------------
	rsc_state_type state_ff;
	rsc_state_type nxt_state;
	logic master_ff;

	always_comb begin
		case (state_ff)
			RSC_ST_HELD: nxt_state = src_any ? RSC_ST_HELD : RSC_ST_RUN;
			RSC_ST_RUN: nxt_state = src_any ? RSC_ST_HELD : RSC_ST_RUN;
			default: nxt_state = RSC_ST_HELD;
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			state_ff <= RSC_ST_HELD;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Registered so release always lands on a clock edge
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			master_ff <= 1'b1;
		end else begin
			master_ff <= (nxt_state == RSC_ST_HELD);
		end
	end

	assign master_reset_out = master_ff;

	// ----------------------------------------------------------------
	// Cause flags
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] hw_set;
	logic [DATA_W-1:0] cause_q;

	always_comb begin
		hw_set = '0;
		hw_set[`RSC_BIT_TRAP] = trap_conflict_reset_in;
		// Two sources share one flag
		hw_set[`RSC_BIT_OPCODE] = illegal_opcode_reset_in | uninit_wreg_reset_in;
		hw_set[`RSC_BIT_CFG] = config_mismatch_reset_in;
		hw_set[`RSC_BIT_EXT] = ext_src;
		hw_set[`RSC_BIT_INSTR] = reset_instruction_event_in;
		hw_set[`RSC_BIT_WDOG] = watchdog_timeout_reset_in;
		hw_set[`RSC_BIT_BROWN] = brown_src;
	end

	// Power-on value is the only reset; other resets keep the flags
	rsc_flag_bits #(
		.WIDTH(DATA_W),
		.RESET_VAL(`RSC_CAUSE_POR_VAL),
		.IMPL_MASK(`RSC_CAUSE_IMPL),
		.WRITE_ONE_CLEAR(1'b0)
	) u_cause (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.wr_en_in(wr_cause),
		.wr_data_in(wr_data_in),
		.hw_set_in(hw_set),
		.flags_out(cause_q)
	);

	// ----------------------------------------------------------------
	// Reset event interrupt
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] prev_set_ff;
	logic [DATA_W-1:0] event_set;
	logic [DATA_W-1:0] irq_stat_q;
	logic [DATA_W-1:0] irq_mask_ff;

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			prev_set_ff <= '0;
		end else begin
			prev_set_ff <= hw_set;
		end
	end

	assign event_set = hw_set & ~prev_set_ff;

	rsc_flag_bits #(
		.WIDTH(DATA_W),
		.RESET_VAL(`RSC_ZERO_VAL),
		.IMPL_MASK(`RSC_CAUSE_IMPL),
		.WRITE_ONE_CLEAR(1'b1)
	) u_irq_stat (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.wr_en_in(wr_irq_stat),
		.wr_data_in(wr_data_in),
		.hw_set_in(event_set),
		.flags_out(irq_stat_q)
	);

	// Mask survives master reset so the event is seen afterwards
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			irq_mask_ff <= '0;
		end else if (wr_irq_mask) begin
			irq_mask_ff <= wr_data_in & `RSC_CAUSE_IMPL;
		end
	end

	assign irq_out = |(irq_stat_q & irq_mask_ff);

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] rd_data_ff;
	logic [DATA_W-1:0] nxt_rd_data;

	always_comb begin
		case (rd_sel)
			RSC_SEL_CAUSE: nxt_rd_data = cause_q;
			RSC_SEL_IRQ_STAT: nxt_rd_data = irq_stat_q;
			RSC_SEL_IRQ_MASK: nxt_rd_data = irq_mask_ff;
			RSC_SEL_LIVE: nxt_rd_data = DATA_W'(src_live);
			default: nxt_rd_data = '0;
		endcase
	end

	// Read data is forced clear while the master reset holds
	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in || master_ff) begin
			rd_data_ff <= '0;
		end else if (rd_en_in) begin
			rd_data_ff <= nxt_rd_data;
		end else begin
			rd_data_ff <= '0;
		end
	end

	assign rd_data_out = rd_data_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_master_any: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		src_any |=> master_reset_out
	) else $error("master reset missed an active source");

	a_master_release: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(!src_any ##1 !src_any) |-> ##1 !master_reset_out
	) else $error("master reset not released");

	a_wreg_flag: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		uninit_wreg_reset_in |=> cause_q[`RSC_BIT_OPCODE] && master_reset_out
	) else $error("working register source not taken");

	a_cause_set: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(trap_conflict_reset_in || watchdog_timeout_reset_in)
		|=> (cause_q[`RSC_BIT_TRAP] || !$past(trap_conflict_reset_in))
		&& (cause_q[`RSC_BIT_WDOG] || !$past(watchdog_timeout_reset_in))
	) else $error("cause flag not set by its source");

	a_por_value: assert property (
		@(posedge sys_clk_in)
		!rst_n_in |=> cause_q == `RSC_CAUSE_POR_VAL
	) else $error("power-on cause value wrong");

	a_sw_write: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(wr_cause && hw_set == '0)
		|=> cause_q == ($past(wr_data_in) & `RSC_CAUSE_IMPL)
	) else $error("software write to cause flags lost");

	a_sw_no_reset: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(wr_cause && !src_any) |=> !master_reset_out
	) else $error("software flag write caused a reset");

	a_rd_forced: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		master_reset_out |=> rd_data_out == '0
	) else $error("read data not cleared under master reset");

	a_hw_priority: assert property (
		@(posedge sys_clk_in) disable iff (!rst_n_in)
		(wr_cause && hw_set != '0)
		|=> (cause_q & $past(hw_set)) == $past(hw_set)
	) else $error("software write beat a hardware set");

endmodule : rsc_combiner

// *** rsc_flag_bits.sv ***
/*
 * Row of hardware-settable flag bits with a software write port.
 * Assumes hardware sets are one clock long or longer levels.
 */
`timescale 1ns/1ps

module rsc_flag_bits #(
	parameter int WIDTH = 16,
	parameter logic [WIDTH-1:0] RESET_VAL = '0,
	parameter logic [WIDTH-1:0] IMPL_MASK = '1,
	parameter bit WRITE_ONE_CLEAR = 1'b0
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic wr_en_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic [WIDTH-1:0] hw_set_in,
	output logic [WIDTH-1:0] flags_out
);

	logic [WIDTH-1:0] flags_ff;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("rsc_flag_bits needs WIDTH of 1 or more");
		end
	endgenerate

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_flag
			if (IMPL_MASK[i]) begin : g_impl
				// Hardware set beats any write in the same cycle
				always_ff @(posedge sys_clk_in) begin
					if (!rst_n_in) begin
						flags_ff[i] <= RESET_VAL[i];
					end else if (hw_set_in[i]) begin
						flags_ff[i] <= 1'b1;
					end else if (wr_en_in) begin
						if (WRITE_ONE_CLEAR) begin
							flags_ff[i] <= flags_ff[i] & ~wr_data_in[i];
						end else begin
							flags_ff[i] <= wr_data_in[i];
						end
					end
				end
			end else begin : g_none
				// Same kind of driver as the other bits of the row
				always_ff @(posedge sys_clk_in) begin
					flags_ff[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign flags_out = flags_ff;

endmodule : rsc_flag_bits

// *** rsc_pkg.sv ***
/*
 * Types shared by the reset source combiner files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rsc_pkg;

	// ----------------------------------------------------------------
	// Register select
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		RSC_SEL_CAUSE = 3'b000,
		RSC_SEL_IRQ_STAT = 3'b001,
		RSC_SEL_IRQ_MASK = 3'b010,
		RSC_SEL_LIVE = 3'b011,
		RSC_SEL_NONE = 3'b100
	} rsc_sel_type;

	// ----------------------------------------------------------------
	// Master reset state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RSC_ST_HELD = 2'b00,
		RSC_ST_RUN = 2'b01
	} rsc_state_type;

endpackage : rsc_pkg

// *** rsc_sync.sv ***
/*
 * Three-stage input conditioner for levels from outside the clock.
 * Assumes a single clock and a synchronous active low reset.
 */
`timescale 1ns/1ps

module rsc_sync #(
	parameter int WIDTH = 2
) (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] level_out
);

	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] stage2_ff;
	logic [WIDTH-1:0] stage3_ff;
	logic [WIDTH-1:0] level_ff;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("rsc_sync needs WIDTH of 1 or more");
		end
	endgenerate

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			meta_ff <= '0;
			stage2_ff <= '0;
			stage3_ff <= '0;
		end else begin
			meta_ff <= async_in;
			stage2_ff <= meta_ff;
			stage3_ff <= stage2_ff;
		end
	end

	// Change taken only once the last two stages agree
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge sys_clk_in) begin
				if (!rst_n_in) begin
					level_ff[i] <= 1'b0;
				end else if (stage2_ff[i] == stage3_ff[i]) begin
					level_ff[i] <= stage3_ff[i];
				end
			end
		end
	endgenerate

	assign level_out = level_ff;

endmodule : rsc_sync

// *** tb_rsc_combiner.sv ***
/*
 * Self-checking testbench for the reset source combiner.
 * Assumes rsc_cfg.svh offsets and bit positions and a 100 MHz clock.
 */
`timescale 1ns/1ps
`include "rsc_cfg.svh"

module tb_rsc_combiner;
	logic sys_clk_in;
	logic rst_n_in;
	logic [5:0] sc_src;
	logic [1:0] as_src;
	logic [7:0] addr;
	logic [15:0] wdata;
	logic wr_en;
	logic rd_en;
	logic [15:0] rd_data;
	logic master_rst;
	logic irq;
	logic [15:0] got;
	logic [1:0] irq_seen;
	int err_total;
	int checks_done;
	// Order: instr, wdog, cfg, trap, opcode, wreg (last two share one flag)
	localparam int SC_BIT [6] = '{6, 4, 9, 15, 14, 14};
	localparam int AS_BIT [2] = '{7, 1};

	rsc_combiner i_rsc_combiner (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.external_pin_reset_in(as_src[0]),
		.reset_instruction_event_in(sc_src[0]),
		.watchdog_timeout_reset_in(sc_src[1]),
		.brown_out_reset_in(as_src[1]),
		.config_mismatch_reset_in(sc_src[2]),
		.trap_conflict_reset_in(sc_src[3]),
		.illegal_opcode_reset_in(sc_src[4]),
		.uninit_wreg_reset_in(sc_src[5]),
		.addr_in(addr),
		.wr_data_in(wdata),
		.wr_en_in(wr_en),
		.rd_en_in(rd_en),
		.rd_data_out(rd_data),
		.master_reset_out(master_rst),
		.irq_out(irq)
	);

	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic close_out;
		$display("Checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk_in);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk_in);
		wr_en <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge sys_clk_in);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk_in);
		rd_en <= 1'b0;
		#1;
		d = rd_data;
	endtask : rd

	// Bounded wait for the master reset to drop
	task automatic wait_quiet;
		for (int n = 0; n < 20 && master_rst !== 1'b0; n++) begin
			@(posedge sys_clk_in);
			#1;
		end
		if (master_rst !== 1'b0) begin
			err_total++;
			$display("BAD master_reset_out release expected 0 seen %b", master_rst);
			close_out();
		end
	endtask : wait_quiet

	task automatic por;
		@(posedge sys_clk_in);
		rst_n_in <= 1'b0;
		repeat (6) @(posedge sys_clk_in);
		#1;
		chk("master in por", 16'h1, {15'h0, master_rst});
		chk("irq in por", 16'h0, {15'h0, irq});
		@(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		wait_quiet();
		rd(`RSC_OFF_CAUSE, got);
		chk("cause after por", `RSC_CAUSE_POR_VAL, got);
	endtask : por

	initial begin
		#100000;
		err_total++;
		$display("BAD timeout expected finish seen hang");
		close_out();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n_in = 1'b0;
		sc_src = '0;
		as_src = '0;
		addr = '0;
		wdata = '0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		err_total = 0;
		checks_done = 0;
		por();
		wr(`RSC_OFF_CAUSE, 16'h0000);
		wr(`RSC_OFF_IRQ_STAT, 16'hffff);
		for (int i = 0; i < 6; i++) begin
			@(posedge sys_clk_in);
			sc_src[i] <= 1'b1;
			@(posedge sys_clk_in);
			sc_src[i] <= 1'b0;
			#1;
			chk("master on source", 16'h1, {15'h0, master_rst});
			@(posedge sys_clk_in);
			#1;
			chk("master after source", 16'h0, {15'h0, master_rst});
			rd(`RSC_OFF_CAUSE, got);
			chk("cause flag", 16'h1 << SC_BIT[i], got);
			wr(`RSC_OFF_CAUSE, 16'h0000);
		end
		// Pin and brown-out pass a conditioner, so hold them long
		for (int j = 0; j < 2; j++) begin
			@(posedge sys_clk_in);
			as_src[j] <= 1'b1;
			repeat (8) @(posedge sys_clk_in);
			#1;
			chk("master on async", 16'h1, {15'h0, master_rst});
			@(posedge sys_clk_in);
			as_src[j] <= 1'b0;
			wait_quiet();
			rd(`RSC_OFF_CAUSE, got);
			chk("async cause flag", 16'h1 << AS_BIT[j], got);
			wr(`RSC_OFF_CAUSE, 16'h0000);
		end
		@(posedge sys_clk_in);
		sc_src[1] <= 1'b1;
		rd(`RSC_OFF_CAUSE, got);
		chk("read in reset", 16'h0000, got);
		chk("master held", 16'h1, {15'h0, master_rst});
		@(posedge sys_clk_in);
		sc_src[1] <= 1'b0;
		#1;
		chk("master last source", 16'h1, {15'h0, master_rst});
		@(posedge sys_clk_in);
		#1;
		chk("master release", 16'h0, {15'h0, master_rst});
		wr(`RSC_OFF_CAUSE, 16'hffff);
		repeat (2) @(posedge sys_clk_in);
		#1;
		chk("master after sw set", 16'h0, {15'h0, master_rst});
		rd(`RSC_OFF_CAUSE, got);
		chk("cause sw set", `RSC_CAUSE_IMPL, got);
		wr(`RSC_OFF_CAUSE, 16'h0000);
		rd(`RSC_OFF_CAUSE, got);
		chk("cause sw clear", 16'h0000, got);
		// Live view is readable only before the master reset rises
		@(posedge sys_clk_in);
		sc_src[2] <= 1'b1;
		addr <= `RSC_OFF_LIVE;
		rd_en <= 1'b1;
		@(posedge sys_clk_in);
		sc_src[2] <= 1'b0;
		rd_en <= 1'b0;
		#1;
		chk("live sources", 16'h0020, rd_data);
		wait_quiet();
		// Clearing write and watchdog event land on the same edge
		@(posedge sys_clk_in);
		sc_src[1] <= 1'b1;
		addr <= `RSC_OFF_CAUSE;
		wdata <= 16'h0000;
		wr_en <= 1'b1;
		@(posedge sys_clk_in);
		sc_src[1] <= 1'b0;
		wr_en <= 1'b0;
		wait_quiet();
		rd(`RSC_OFF_CAUSE, got);
		chk("hw beats sw", 16'h0010, got);
		rd(`RSC_OFF_IRQ_STAT, got);
		chk("irq status", 16'hc2d2, got & 16'hc2d2);
		wr(`RSC_OFF_IRQ_MASK, 16'h0000);
		#1;
		irq_seen[0] = irq;
		wr(`RSC_OFF_IRQ_MASK, 16'hffff);
		#1;
		irq_seen[1] = irq;
		chk("irq mask effect", 16'h0002, {14'h0, irq_seen});
		wr(`RSC_OFF_IRQ_STAT, 16'hffff);
		rd(`RSC_OFF_IRQ_STAT, got);
		chk("irq status clear", 16'h0000, got);
		chk("irq after clear", 16'h0, {15'h0, irq});
		wr(8'h10, 16'hffff);
		rd(8'h10, got);
		chk("unmapped read", 16'h0000, got);
		wr(`RSC_OFF_CAUSE, 16'hffff);
		por();
		close_out();
	end
endmodule : tb_rsc_combiner
